// ==== rtl/adc_ctrl_pkg.sv ====
// Constants for the converter main control register decode.
// Assumes a serial configuration port delivers whole 16-bit register writes.
package adc_ctrl_pkg;
    localparam int REG_WIDTH = 16;
    localparam int ADDR_WIDTH = 7;
    localparam logic [6:0] MAIN_CONTROL_ADDR = 7'h01;
    localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0000;
    // Writable field mask: unused and must-be-zero bits are never stored
    localparam logic [15:0] MAIN_CONTROL_MASK = 16'h11BF;
    localparam int MODE_LSB = 0;
    localparam int INTERLEAVE_LSB = 2;
    localparam int CORE_COUNT = 4;
    localparam logic [3:0] CORES_RESET = 4'hF;
    localparam logic [3:0] ROUTE_RESET = 4'h1;
    localparam int PAIR_LSB = 0;
    localparam int STANDBY_LSB = 4;
    localparam int FORMAT_BIT = 7;
    localparam int BANDWIDTH_BIT = 8;
    localparam int TEST_BIT = 12;

    typedef enum logic [1:0] {
        MODE_FOUR = 2'h0,
        MODE_TWO = 2'h1,
        MODE_ONE = 2'h2,
        MODE_COMMON = 2'h3
    } interleave_t;

    typedef enum logic [1:0] {
        POWER_DOWN_CODE_NONE = 2'h0,
        POWER_DOWN_CODE_FIRST = 2'h1,
        POWER_DOWN_CODE_SECOND = 2'h2,
        POWER_DOWN_CODE_FULL = 2'h3
    } power_down_code_t;
endpackage

// ==== rtl/quad_adc_mode_control_reg.sv ====
// Main control register of a quad interleavable converter and its decode.
// Assumes the serial port front end presents an aligned write strobe, address and data in clk.
// Function
// - Mode 00: four independent cores at 1.25 GSps
// - Mode 01: paired interleave, pair chosen by bits
// - Mode 10: all cores into one input
// - Mode 11: common input, simultaneous sampling
// - Four-channel standby: AB, CD or all
// - Two-channel standby: first, second or both
// - Single-channel: any nonzero standby means full
// - Common input: any nonzero standby means full
// - Bit 8 selects nominal or full bandwidth
// - Test bit replaces samples with pattern
module quad_adc_mode_control_reg
    import adc_ctrl_pkg::*;
#(
    parameter int NUM_CORES = CORE_COUNT,
    parameter int CTRL_BITS = REG_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cfg_write,
    input wire logic [ADDR_WIDTH-1:0] cfg_addr,
    input wire logic [CTRL_BITS-1:0] cfg_wdata,
    output logic [CTRL_BITS-1:0] cfg_rdata,
    output logic [1:0] interleave_select,
    output logic [1:0] input_select,
    output logic [NUM_CORES-1:0] core_active,
    output logic [NUM_CORES-1:0] input_route_a,
    output logic full_standby,
    output logic gray_output,
    output logic full_bandwidth,
    output logic test_pattern_enable,
    output logic sync_required
);
    // Half of the cores follow each standby bit in the split modes
    localparam int HALF_CORES = NUM_CORES / 2;

    // The decode below only knows the quad arrangement and one 16-bit word
    if (NUM_CORES != CORE_COUNT) begin : g_bad_cores
        $error("NUM_CORES must be four for this decode");
    end
    if (CTRL_BITS != REG_WIDTH) begin : g_bad_width
        $error("CTRL_BITS must be sixteen for this decode");
    end

    // Stored control word
    logic [CTRL_BITS-1:0] converter_main_control;
    logic [CTRL_BITS-1:0] next_control;
    logic [CTRL_BITS-1:0] next_rdata;
    logic write_hit;

    // Fields pulled from the staged word
    interleave_t mode;
    power_down_code_t power_down_code;
    logic [1:0] standby_bits;
    logic [1:0] selected_input;
    logic [1:0] route_index;

    // Per-core decisions
    logic [NUM_CORES-1:0] core_down;
    logic [NUM_CORES-1:0] core_routed;

    // Next values of the outputs
    logic [1:0] next_interleave;
    logic [1:0] next_input;
    logic [NUM_CORES-1:0] next_active;
    logic [NUM_CORES-1:0] next_route;
    logic next_full_standby;
    logic next_gray;
    logic next_bandwidth;
    logic next_test;
    logic next_sync;

    // Register write; unused bits never stored so they cannot steer anything
    always_comb begin
        write_hit = cfg_write && (cfg_addr == MAIN_CONTROL_ADDR);
        next_control = converter_main_control;
        if (write_hit) begin
            next_control = cfg_wdata & MAIN_CONTROL_MASK;
        end
        next_rdata = next_control;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            converter_main_control <= MAIN_CONTROL_RESET;
            cfg_rdata <= MAIN_CONTROL_RESET;
        end else begin
            converter_main_control <= next_control;
            cfg_rdata <= next_rdata;
        end
    end

    // Decode the staged word so every output moves at the write edge itself
    always_comb begin
        mode = interleave_t'(next_control[INTERLEAVE_LSB +: 2]);
        power_down_code = power_down_code_t'(next_control[STANDBY_LSB +: 2]);
        standby_bits = next_control[STANDBY_LSB +: 2];
        selected_input = next_control[PAIR_LSB +: 2];
        case (mode)
            MODE_FOUR: begin
                // Bits 1:0 are ignored here
                route_index = 2'h0;
            end
            MODE_TWO: begin
                // Bit 0 picks A or B; bit 1 does not steer the route and only reaches input_select
                route_index = {1'b0, selected_input[0]};
            end
            MODE_ONE: begin
                route_index = selected_input;
            end
            MODE_COMMON: begin
                route_index = selected_input;
            end
            default: begin
                route_index = 2'h0;
            end
        endcase
    end

    // One decision per core; the split modes share the A/B and C/D halves
    for (genvar k = 0; k < NUM_CORES; k++) begin : g_core
        localparam int SIDE = (k < HALF_CORES) ? 0 : 1;
        // Interleaved single and common modes cannot run a partial set
        assign core_down[k] = (mode == MODE_FOUR || mode == MODE_TWO) ? standby_bits[SIDE]
            : (power_down_code != POWER_DOWN_CODE_NONE);
        assign core_routed[k] = (route_index == 2'(k));
    end

    // Mode and routing group
    always_comb begin
        next_interleave = mode;
        if (mode == MODE_FOUR) begin
            next_input = 2'h0;
        end else begin
            next_input = selected_input;
        end
        next_route = core_routed;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            interleave_select <= 2'h0;
            input_select <= 2'h0;
            input_route_a <= ROUTE_RESET;
        end else begin
            interleave_select <= next_interleave;
            input_select <= next_input;
            input_route_a <= next_route;
        end
    end

    // Power group; full standby is simply every core down
    always_comb begin
        next_active = ~core_down;
        next_full_standby = &core_down;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_active <= CORES_RESET;
            full_standby <= 1'b0;
        end else begin
            core_active <= next_active;
            full_standby <= next_full_standby;
        end
    end

    // Output format group
    always_comb begin
        next_gray = next_control[FORMAT_BIT];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gray_output <= 1'b0;
        end else begin
            gray_output <= next_gray;
        end
    end

    // Bandwidth group
    always_comb begin
        next_bandwidth = next_control[BANDWIDTH_BIT];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_bandwidth <= 1'b0;
        end else begin
            full_bandwidth <= next_bandwidth;
        end
    end

    // Test group; the sync flag only tells the system, it cannot apply sync
    always_comb begin
        next_test = next_control[TEST_BIT];
        next_sync = next_control[TEST_BIT];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            test_pattern_enable <= 1'b0;
            sync_required <= 1'b0;
        end else begin
            test_pattern_enable <= next_test;
            sync_required <= next_sync;
        end
    end
endmodule // quad_adc_mode_control_reg

// ==== tb/cfg_host.sv ====
// Host model issuing configuration writes.
// Assumes one-cycle write pulses at the rising edge.
module cfg_host (
    input logic clk,
    output logic cfg_write, sync_in_pos, sync_in_neg,
    output logic [6:0] cfg_addr,
    output logic [15:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cfg_write, sync_in_pos, sync_in_neg, cfg_addr, cfg_wdata} = '0;
    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        cfg_write <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d & 16'hD7FF; // Must-be-zero bits cleared
        {sync_in_pos, sync_in_neg} <= {d[12], !d[12]}; // Sync applied with test mode
        @(posedge clk);
        cfg_write <= 1'b0;
        cfg_addr <= ~a; // Released bus never shows the old value
        cfg_wdata <= ~d;
    endtask
endmodule // cfg_host

// ==== tb/quad_adc_mode_control_reg_assertions.sv ====
// Checker of the control decode outputs.
// Sees top ports only; bound below.
module quad_adc_mode_control_reg_assertions (
    input logic clk, rstn, cfg_write, full_standby, gray_output, full_bandwidth, test_pattern_enable, sync_required,
    input logic [6:0] cfg_addr,
    input logic [15:0] cfg_wdata, cfg_rdata,
    input logic [1:0] interleave_select, input_select,
    input logic [3:0] core_active, input_route_a
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr; cfg_write && cfg_addr == 7'h01; endsequence
    property p_wr; s_wr |=> cfg_rdata == ($past(cfg_wdata) & 16'h11BF); endproperty
    a_wr: assert property (p_wr) else $error("store");
    property p_hold; !(cfg_write && cfg_addr == 7'h01) |=> $stable(cfg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_mode; interleave_select == cfg_rdata[3:2]; endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_four; interleave_select == 2'h0 |-> input_select == 2'h0 && input_route_a == 4'h1; endproperty
    a_four: assert property (p_four) else $error("four");
    property p_part; interleave_select < 2 |-> core_active == ~{{2{cfg_rdata[5]}}, {2{cfg_rdata[4]}}}; endproperty
    a_part: assert property (p_part) else $error("part");
    property p_full; interleave_select > 1 |-> core_active == (cfg_rdata[5:4] ? 4'h0 : 4'hF); endproperty
    a_full: assert property (p_full) else $error("full");
    property p_route; interleave_select > 1 |-> input_route_a == 4'h1 << cfg_rdata[1:0]; endproperty
    a_route: assert property (p_route) else $error("route");
    property p_flag; {gray_output, full_bandwidth, test_pattern_enable, sync_required, full_standby}
        == {cfg_rdata[7], cfg_rdata[8], cfg_rdata[12], cfg_rdata[12], core_active == 4'h0}; endproperty
    a_flag: assert property (p_flag) else $error("flags");
endmodule // quad_adc_mode_control_reg_assertions
bind quad_adc_mode_control_reg quad_adc_mode_control_reg_assertions i_quad_adc_mode_control_reg_assertions (.*);

// ==== tb/test_quad_adc_mode_control_reg.sv ====
// Bench comparing the decode with a reference model.
// Assumes the host model issues every write.
module test_quad_adc_mode_control_reg;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, cfg_write, full_standby, gray_output, full_bandwidth, test_pattern_enable, sync_required;
    logic sync_in_pos, sync_in_neg;
    logic [6:0] cfg_addr, a;
    logic [15:0] cfg_wdata, cfg_rdata, d, r = 0;
    logic [1:0] interleave_select, input_select, m;
    logic [3:0] core_active, input_route_a, ec;
    int failures = 0, n_compared = 0, seed = 45937;
    always #10 clk = ~clk;
    quad_adc_mode_control_reg i_quad_adc_mode_control_reg (.*);
    cfg_host i_cfg_host (.*);
    task chk(input string s, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task check_all;
        @(negedge clk);
        m = r[3:2];
        ec = m > 1 ? (r[5:4] ? 4'h0 : 4'hF) : ~{{2{r[5]}}, {2{r[4]}}};
        chk("rdata", r, cfg_rdata);
        chk("mode", {m, m ? r[1:0] : 2'h0}, {interleave_select, input_select});
        chk("cores", ec, core_active);
        chk("route", m > 1 ? 4'h1 << r[1:0] : m && r[0] ? 4'h2 : 4'h1, input_route_a);
        chk("flags", {ec == 0, r[7], r[8], r[12], r[12]},
            {full_standby, gray_output, full_bandwidth, test_pattern_enable, sync_required});
    endtask
    task test_done;
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        check_all;
        // Every mode, pair and standby code first, then mixed addresses
        for (int i = 0; i < 160; i++) begin
            d = $random(seed);
            a = i < 64 ? 7'h01 : 7'({$random(seed)} % 3);
            if (i < 64) d[5:0] = 6'(i);
            i_cfg_host.wr(a, d);
            if (a == 7'h01) r = d & 16'h11BF;
            check_all;
            if (i == 100) begin
                @(posedge clk) rstn <= 1'b0;
                @(posedge clk) rstn <= 1'b1;
                r = 0;
                check_all;
            end
        end
        test_done;
    end
endmodule // test_quad_adc_mode_control_reg
